// ---- shared/qwp_map.svh ----
`ifndef QWP_MAP_SVH
`define QWP_MAP_SVH

`define QWP_CHANNELS 4
`define QWP_SLOTS 4
`define QWP_WIDTH 6
`define QWP_TAPS 64
`define QWP_POS_MAX 6'h3F
`define QWP_POS_MIN 6'h00
`define QWP_WIPER_RST 6'h00
`define QWP_NV_BLANK 6'h20
`define QWP_TYPE_CODE 3'h2
`define QWP_LAST_BIT 4'h7
`define QWP_ACK_SLOT 4'h8

`define QWP_OP_RD_WIPER 4'h9
`define QWP_OP_WR_WIPER 4'hA
`define QWP_OP_RD_STORED 4'hB
`define QWP_OP_WR_STORED 4'hC
`define QWP_OP_RECALL 4'hD
`define QWP_OP_SAVE 4'hE
`define QWP_OP_STEP 4'h2

`endif

// ---- shared/qwp_pkg.sv ----
package qwp_pkg;

    typedef logic [5:0] qwp_pos_t;

    typedef enum logic [2:0] {
        QWP_IDLE = 3'b000,
        QWP_ADDR = 3'b001,
        QWP_CMD = 3'b010,
        QWP_DATA = 3'b011,
        QWP_STEP = 3'b100,
        QWP_READ = 3'b101,
        QWP_SKIP = 3'b110
    } qwp_state_t;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] pot;
        logic [1:0] slot;
    } qwp_cmd_t;

    typedef struct packed {
        logic ack;
        logic tx;
        logic [7:0] data;
    } qwp_link_ctl_t;

endpackage

// ---- src/qwp_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "qwp_map.svh"

module qwp_bank #(
    parameter int CHANNELS = `QWP_CHANNELS,
    parameter int SLOTS = `QWP_SLOTS,
    parameter int TAPS = `QWP_TAPS,
    // Upper address bits; value is arbitrary
    parameter logic [2:0] TYPE_CODE = `QWP_TYPE_CODE
) (
    // Core clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Blank-memory strobe: sets every stored setting to its erased value
    input wire logic nv_clear_in,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [3:0] device_select_inputs_in,
    // Wiper side
    output qwp_pkg::qwp_pos_t [CHANNELS-1:0] wiper_position_register_out,
    output logic [CHANNELS-1:0][TAPS-1:0] tap_sel_out
);

    // Pin synchronisers
    logic scl_m_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_p_q;
    logic [3:0] sel_m_q;
    logic [3:0] sel_s_q;
    logic evt_m_q;
    logic evt_s_q;
    logic evt_p_q;

    // Frame control
    logic lrst_q;
    logic clr_q;
    logic arm_q;
    logic start_w;
    logic stop_w;
    logic byte_evt;

    // Link exchange
    logic [7:0] rx_w;
    logic evt_tgl_w;
    qwp_pkg::qwp_link_ctl_t ctl_q;
    qwp_pkg::qwp_cmd_t cmd_w;

    // Core state
    qwp_pkg::qwp_state_t state_q;
    qwp_pkg::qwp_state_t state_d;
    qwp_pkg::qwp_pos_t wiper_q [CHANNELS];
    qwp_pkg::qwp_pos_t stored_q [CHANNELS*SLOTS];
    logic recall_q;
    logic ptr_nv_q;
    logic [1:0] ptr_pot_q;
    logic [1:0] ptr_slot_q;

    // Decoded actions
    logic addr_hit;
    logic do_wr_wiper;
    logic do_wr_stored;
    logic do_recall;
    logic do_save;
    logic do_step;
    logic do_ptr;
    logic [7:0] rd_byte;

    function automatic int nv_idx(input logic [1:0] pot, input logic [1:0] slot);
        nv_idx = int'(pot) * SLOTS + int'(slot);
    endfunction

    function automatic qwp_pkg::qwp_pos_t step_pos(input qwp_pkg::qwp_pos_t v,
                                                  input logic up);
        if (up) begin
            step_pos = (v == `QWP_POS_MAX) ? v : v + 6'h01;
        end else begin
            step_pos = (v == `QWP_POS_MIN) ? v : v - 6'h01;
        end
    endfunction

    // Master owns the clock; its edges run the link logic
    qwp_link u_link (
        .scl_in(scl_in),
        .lrst_in(lrst_q),
        .clr_in(clr_q),
        .sda_in(sda_in),
        .sda_oe_out(sda_oe_out),
        .ctl_in(ctl_q),
        .rx_byte_out(rx_w),
        .evt_tgl_out(evt_tgl_w)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sel_m_q <= 4'h0;
            sel_s_q <= 4'h0;
        end else begin
            sel_m_q <= device_select_inputs_in;
            sel_s_q <= sel_m_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            evt_m_q <= 1'b0;
            evt_s_q <= 1'b0;
            evt_p_q <= 1'b0;
        end else begin
            evt_m_q <= evt_tgl_w;
            evt_s_q <= evt_m_q;
            evt_p_q <= evt_s_q;
        end
    end

    // Start and stop are data edges while the clock stays high
    assign start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_w = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign byte_evt = evt_s_q ^ evt_p_q;

    // Link logic is held clear between frames and pulsed clear at each start
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lrst_q <= 1'b1;
            clr_q <= 1'b1;
            arm_q <= 1'b0;
        end else begin
            lrst_q <= 1'b0;
            if (start_w) begin
                clr_q <= 1'b1;
                arm_q <= 1'b1;
            end else if (stop_w) begin
                clr_q <= 1'b1;
                arm_q <= 1'b0;
            end else if (arm_q) begin
                clr_q <= 1'b0;
                arm_q <= 1'b0;
            end
        end
    end

    assign cmd_w = qwp_pkg::qwp_cmd_t'(rx_w);
    assign addr_hit = (rx_w[7:5] == TYPE_CODE)
        && (rx_w[4:1] == sel_s_q);

    always_comb begin
        rd_byte = 8'h00;
        if (ptr_nv_q) begin
            rd_byte[5:0] = stored_q[nv_idx(ptr_pot_q, ptr_slot_q)];
        end else begin
            rd_byte[5:0] = wiper_q[ptr_pot_q];
        end
    end

    // Byte decode
    always_comb begin
        state_d = state_q;
        do_wr_wiper = 1'b0;
        do_wr_stored = 1'b0;
        do_recall = 1'b0;
        do_save = 1'b0;
        do_step = 1'b0;
        do_ptr = 1'b0;
        if (byte_evt) begin
            case (state_q)
                qwp_pkg::QWP_ADDR: begin
                    if (!addr_hit) begin
                        state_d = qwp_pkg::QWP_SKIP;
                    end else if (rx_w[0]) begin
                        state_d = qwp_pkg::QWP_READ;
                    end else begin
                        state_d = qwp_pkg::QWP_CMD;
                    end
                end
                qwp_pkg::QWP_CMD: begin
                    do_ptr = 1'b1;
                    state_d = qwp_pkg::QWP_SKIP;
                    case (cmd_w.op)
                        `QWP_OP_RD_WIPER: begin
                            state_d = qwp_pkg::QWP_IDLE;
                        end
                        `QWP_OP_RD_STORED: begin
                            state_d = qwp_pkg::QWP_IDLE;
                        end
                        `QWP_OP_WR_WIPER: begin
                            state_d = qwp_pkg::QWP_DATA;
                        end
                        `QWP_OP_WR_STORED: begin
                            state_d = qwp_pkg::QWP_DATA;
                        end
                        `QWP_OP_RECALL: begin
                            do_recall = 1'b1;
                            state_d = qwp_pkg::QWP_IDLE;
                        end
                        `QWP_OP_SAVE: begin
                            do_save = 1'b1;
                            state_d = qwp_pkg::QWP_IDLE;
                        end
                        `QWP_OP_STEP: begin
                            state_d = qwp_pkg::QWP_STEP;
                        end
                        default: begin
                            do_ptr = 1'b0;
                        end
                    endcase
                end
                qwp_pkg::QWP_DATA: begin
                    do_wr_wiper = ~ptr_nv_q;
                    do_wr_stored = ptr_nv_q;
                    state_d = qwp_pkg::QWP_IDLE;
                end
                qwp_pkg::QWP_STEP: begin
                    do_step = 1'b1;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= qwp_pkg::QWP_SKIP;
        end else if (start_w) begin
            state_q <= qwp_pkg::QWP_ADDR;
        end else if (stop_w) begin
            state_q <= qwp_pkg::QWP_SKIP;
        end else begin
            state_q <= state_d;
        end
    end

    // Ack and transmit word for the link; stable long before it is used
    always_ff @(posedge clk_in) begin
        if (rst_in || start_w || stop_w) begin
            ctl_q <= '0;
        end else if (byte_evt) begin
            ctl_q.ack <= (state_d != qwp_pkg::QWP_SKIP)
                && (state_d != qwp_pkg::QWP_READ || state_q == qwp_pkg::QWP_ADDR);
            ctl_q.tx <= (state_d == qwp_pkg::QWP_READ);
            ctl_q.data <= rd_byte;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ptr_nv_q <= 1'b0;
            ptr_pot_q <= 2'h0;
            ptr_slot_q <= 2'h0;
        end else if (do_ptr) begin
            ptr_nv_q <= (cmd_w.op == `QWP_OP_RD_STORED)
                || (cmd_w.op == `QWP_OP_WR_STORED);
            ptr_pot_q <= cmd_w.pot;
            ptr_slot_q <= cmd_w.slot;
        end
    end

    // One load of the first stored settings after reset release
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            recall_q <= 1'b1;
        end else begin
            recall_q <= 1'b0;
        end
    end

    // Stored settings survive core reset; only the blank strobe erases them
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < CHANNELS*SLOTS; i++) begin
            if (nv_clear_in) begin
                stored_q[i] <= `QWP_NV_BLANK;
            end else if (do_wr_stored && i == nv_idx(ptr_pot_q, ptr_slot_q)) begin
                stored_q[i] <= rx_w[5:0];
            end else if (do_save && i == nv_idx(cmd_w.pot, cmd_w.slot)) begin
                stored_q[i] <= wiper_q[cmd_w.pot];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        for (int c = 0; c < CHANNELS; c++) begin
            if (rst_in) begin
                wiper_q[c] <= `QWP_WIPER_RST;
            end else if (recall_q) begin
                wiper_q[c] <= stored_q[nv_idx(2'(c), 2'h0)];
            end else if (do_wr_wiper && 2'(c) == ptr_pot_q) begin
                wiper_q[c] <= rx_w[5:0];
            end else if (do_recall && 2'(c) == cmd_w.pot) begin
                wiper_q[c] <= stored_q[nv_idx(cmd_w.pot, cmd_w.slot)];
            end else if (do_step && 2'(c) == ptr_pot_q) begin
                wiper_q[c] <= step_pos(wiper_q[c], rx_w[0]);
            end
        end
    end

    // Outputs follow the wipers one clock later, with one tap per channel
    always_ff @(posedge clk_in) begin
        for (int c = 0; c < CHANNELS; c++) begin
            if (rst_in) begin
                wiper_position_register_out[c] <= `QWP_WIPER_RST;
                tap_sel_out[c] <= '0;
            end else begin
                wiper_position_register_out[c] <= wiper_q[c];
                tap_sel_out[c] <= '0;
                tap_sel_out[c][wiper_q[c]] <= 1'b1;
            end
        end
    end

    // Open-drain: the data level is always low, only the enable moves
    always_ff @(posedge clk_in) begin
        sda_out <= 1'b0;
    end

endmodule
`default_nettype wire

// ---- src/qwp_link.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "qwp_map.svh"

module qwp_link (
    // Link clock and clears
    input wire logic scl_in,
    input wire logic lrst_in,
    input wire logic clr_in,
    // Serial data
    input wire logic sda_in,
    output logic sda_oe_out,
    // Core side
    input wire qwp_pkg::qwp_link_ctl_t ctl_in,
    output logic [7:0] rx_byte_out,
    output logic evt_tgl_out
);

    logic [3:0] cnt_q;
    logic [6:0] sr_q;
    logic nack_q;

    // Bits are taken on the rising edge of the master's clock
    always_ff @(posedge scl_in or posedge clr_in) begin
        if (clr_in) begin
            cnt_q <= 4'h0;
            sr_q <= 7'h00;
            nack_q <= 1'b0;
        end else if (cnt_q == `QWP_ACK_SLOT) begin
            cnt_q <= 4'h0;
            nack_q <= sda_in;
        end else begin
            sr_q <= {sr_q[5:0], sda_in};
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Whole byte handed over with a toggle; it stays put for nine clocks
    always_ff @(posedge scl_in or posedge lrst_in) begin
        if (lrst_in) begin
            rx_byte_out <= 8'h00;
            evt_tgl_out <= 1'b0;
        end else if (!clr_in && cnt_q == `QWP_LAST_BIT) begin
            rx_byte_out <= {sr_q, sda_in};
            evt_tgl_out <= ~evt_tgl_out;
        end
    end

    // Data changes only while the clock is low; line is only pulled low
    always_ff @(negedge scl_in or posedge clr_in) begin
        if (clr_in) begin
            sda_oe_out <= 1'b0;
        end else if (cnt_q == `QWP_ACK_SLOT) begin
            sda_oe_out <= ctl_in.ack;
        end else begin
            sda_oe_out <= ctl_in.tx & ~nack_q
                & ~ctl_in.data[3'(3'd7 - cnt_q[2:0])];
        end
    end

endmodule
`default_nettype wire

// ---- tb/qwp_bank_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module qwp_bank_properties #(
    parameter int CHANNELS = 4,
    parameter int TAPS = 64
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // Wiper side
    input wire qwp_pkg::qwp_pos_t [CHANNELS-1:0] wiper_position_register_out,
    input wire logic [CHANNELS-1:0][TAPS-1:0] tap_sel_out
);
    logic scl_q;
    logic sda_q;
    logic [4:0] idle_q;
    logic [3:0] quiet_q;
    logic [2:0] rel_q;
    // Cycles since the last bus clock edge, last data change, reset release
    always_ff @(posedge clk_in) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        idle_q <= (rst_in || scl_q != scl_in) ? 5'h00 : idle_q + {4'h0, idle_q != 5'h1F};
        quiet_q <= (rst_in || sda_q != sda_in) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
        rel_q <= rst_in ? 3'h0 : rel_q + {2'h0, rel_q != 3'h7};
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_drain_only: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_oe_on_low: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("pull-down started while clock high");
    a_oe_stands: assert property (scl_in && scl_q && quiet_q > 4'h8 |->
        $stable(sda_oe_out))
        else $error("pull-down moved while clock high");
    a_reset_clears: assert property (disable iff (1'b0) rst_in [*3] |->
        wiper_position_register_out == '0 && tap_sel_out == '0 && !sda_oe_out)
        else $error("outputs not cleared in reset");
    a_move_on_bus: assert property ($changed(wiper_position_register_out) &&
        rel_q > 3'h3 |-> idle_q < 5'h10)
        else $error("wiper moved without bus activity");
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        sequence s_still;
            $stable(wiper_position_register_out[g]) [*4];
        endsequence
        sequence s_loaded;
            ##[1:3] $onehot(tap_sel_out[g]);
        endsequence
        a_one_tap: assert property ($onehot0(tap_sel_out[g]))
            else $error("more than one tap");
        a_tap_follows: assert property (s_still |->
            tap_sel_out[g][wiper_position_register_out[g]])
            else $error("tap does not match wiper");
        a_recall_power: assert property ($fell(rst_in) |-> s_loaded)
            else $error("no recall");
    end
endmodule
`default_nettype wire

// ---- tb/qwp_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module qwp_master_model (
    // Bus pins
    output logic scl_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    // Quarter bit is 13 link periods of 6 ns; clock stands high between frames
    localparam int Q = 6 * 13;
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic bit_x(input logic b, output logic s);
        sda_oe_out = !b;
        #(Q) scl_out = 1'b1;
        #(Q) s = sda_in;
        #(Q) scl_out = 1'b0;
        #(Q);
    endtask
    task automatic start();
        #1 sda_oe_out = 1'b0;
        #(Q) scl_out = 1'b1;
        #(Q) sda_oe_out = 1'b1;
        #(Q) scl_out = 1'b0;
        #(Q);
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        #(Q) scl_out = 1'b1;
        #(Q) sda_oe_out = 1'b0;
        #(Q);
    endtask
    task automatic send(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, nack);
    endtask
    task automatic recv(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, s);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "qwp_map.svh"
module tb_top;
    typedef struct packed {
        logic [7:0] cmd;
        logic has_d;
        logic [7:0] dat;
        logic [7:0] rcmd;
        logic [5:0] exp;
    } qwp_row_t;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic nv_clear_in = 1'b1;
    logic [3:0] dsel_q = 4'h2;
    logic scl;
    logic m_oe;
    logic sda;
    logic d_out;
    logic d_oe;
    qwp_pkg::qwp_pos_t [3:0] wiper;
    logic [3:0][63:0] tap;
    logic nk;
    logic [7:0] rd;
    int n_fail = 0;
    int samples_checked = 0;
    // Open-drain wire with pull-up
    assign sda = !m_oe && (d_oe ? d_out : 1'b1);
    qwp_row_t rows [11] = '{
        '{8'hA0, 1'b1, 8'h00, 8'h90, 6'h00}, '{8'hA4, 1'b1, 8'hFF, 8'h94, 6'h3F},
        '{8'hA8, 1'b1, 8'h15, 8'h98, 6'h15}, '{8'hAC, 1'b1, 8'h2A, 8'h9C, 6'h2A},
        '{8'hC7, 1'b1, 8'h07, 8'hB7, 6'h07}, '{8'hCC, 1'b1, 8'h11, 8'hBC, 6'h11},
        '{8'hEA, 1'b0, 8'h00, 8'hBA, 6'h15}, '{8'hDC, 1'b0, 8'h00, 8'h9C, 6'h11},
        '{8'h24, 1'b1, 8'h01, 8'h94, 6'h3F}, '{8'h20, 1'b1, 8'h00, 8'h90, 6'h00},
        '{8'h20, 1'b1, 8'h01, 8'h90, 6'h01}
    };
    qwp_bank u_qwp_bank (
        .clk_in(clk_in), .rst_in(rst_in), .nv_clear_in(nv_clear_in),
        .scl_in(scl), .sda_in(sda), .sda_out(d_out), .sda_oe_out(d_oe),
        .device_select_inputs_in(dsel_q),
        .wiper_position_register_out(wiper), .tap_sel_out(tap)
    );
    qwp_master_model u_qwp_master_model (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic end_sim();
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] adr(input logic [3:0] s, input logic r);
        return {`QWP_TYPE_CODE, s, r};
    endfunction
    task automatic tx(input logic [7:0] b, input logic e);
        u_qwp_master_model.send(b, nk);
        check(nk, e);
    endtask
    task automatic rd_reg(input logic [7:0] rc, output logic [7:0] v);
        u_qwp_master_model.start();
        tx(adr(dsel_q, 1'b0), 1'b0);
        tx(rc, 1'b0);
        u_qwp_master_model.start();
        tx(adr(dsel_q, 1'b1), 1'b0);
        u_qwp_master_model.recv(v, 1'b1);
        u_qwp_master_model.stop();
    endtask
    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    initial begin
        #600000;
        n_fail++;
        end_sim();
    end
    initial begin
        // Blank the stored settings while reset is held for six clocks
        repeat (3) @(posedge clk_in);
        nv_clear_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        for (int p = 0; p < 4; p++) begin
            check(wiper[p], `QWP_NV_BLANK);
            check(tap[p], 64'h0000_0000_0000_0001 << `QWP_NV_BLANK);
        end
        foreach (rows[i]) begin
            u_qwp_master_model.start();
            tx(adr(dsel_q, 1'b0), 1'b0);
            tx(rows[i].cmd, 1'b0);
            if (rows[i].has_d) tx(rows[i].dat, 1'b0);
            u_qwp_master_model.stop();
            rd_reg(rows[i].rcmd, rd);
            check(rd, {2'b00, rows[i].exp});
            if (rows[i].rcmd[7:4] == 4'h9) begin
                check(wiper[rows[i].rcmd[3:2]], rows[i].exp);
                check(tap[rows[i].rcmd[3:2]], 64'h0000_0000_0000_0001 << rows[i].exp);
            end
        end
        // Foreign address, then the old address after the select pins move
        u_qwp_master_model.start();
        tx(adr(4'h3, 1'b0), 1'b1);
        u_qwp_master_model.stop();
        @(posedge clk_in);
        dsel_q <= 4'h9;
        repeat (4) @(posedge clk_in);
        u_qwp_master_model.start();
        tx(adr(4'h2, 1'b0), 1'b1);
        u_qwp_master_model.stop();
        // Three down steps back to back in one frame
        u_qwp_master_model.start();
        tx(adr(4'h9, 1'b0), 1'b0);
        tx(8'h28, 1'b0);
        repeat (3) tx(8'h00, 1'b0);
        u_qwp_master_model.stop();
        rd_reg(8'h98, rd);
        check(rd, 8'h12);
        // Unknown opcode is refused; a byte past a completed write changes nothing
        u_qwp_master_model.start();
        tx(adr(4'h9, 1'b0), 1'b0);
        tx(8'h00, 1'b1);
        u_qwp_master_model.start();
        tx(adr(4'h9, 1'b0), 1'b0);
        tx(8'hA8, 1'b0);
        tx(8'h3F, 1'b0);
        tx(8'h05, 1'b0);
        u_qwp_master_model.stop();
        check(wiper[2], 6'h3F);
        // Reset in mid-run recalls slot 0 of each channel
        do_reset();
        check(wiper[3], 6'h11);
        check(wiper[2], `QWP_NV_BLANK);
        check(wiper[0], `QWP_NV_BLANK);
        check(tap[3], 64'h0000_0000_0000_0001 << 6'h11);
        end_sim();
    end
endmodule
bind qwp_bank qwp_bank_properties #(.CHANNELS(CHANNELS), .TAPS(TAPS)) u_qwp_bank_properties (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .wiper_position_register_out(wiper_position_register_out), .tap_sel_out(tap_sel_out)
);
`default_nettype wire
